// ---- verilog/servo_guard_pkg.sv ----
// Constants, register map and types for the servo brake interlock and fault monitor
package servo_guard_pkg;
	// Clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int BRAKE_TIMEOUT_MS = 500;
	localparam int BRAKE_TIMEOUT_CYC = BRAKE_TIMEOUT_MS * CYC_PER_MS;
	localparam int DYN_BRAKE_MS = 15;
	localparam int DYN_BRAKE_CYC = DYN_BRAKE_MS * CYC_PER_MS;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;

	// Measurement widths
	localparam int SPEED_W = 13;
	localparam int VOLT_W = 9;
	localparam int CUR_W = 12;
	localparam int TEMP_W = 8;
	localparam int TORQUE_W = 12;
	localparam int THERM_W = 32;
	localparam int PIN_W = 7;
	localparam int ADDR_W = 8;

	// Limits: 4950 rpm, 100 r/min, 170 V, 410 V
	localparam logic [SPEED_W-1:0] OVERSPEED_RPM = 13'h1356;
	localparam logic [SPEED_W-1:0] BRAKE_SPEED_RPM = 13'h0064;
	localparam logic [VOLT_W-1:0] VBUS_MIN_V = 9'h0AA;
	localparam logic [VOLT_W-1:0] VBUS_MAX_V = 9'h19A;
	localparam logic [CUR_W-1:0] CURRENT_MAX = 12'hC00;
	localparam logic [TEMP_W-1:0] TEMP_MAX = 8'h64;
	localparam logic [TORQUE_W-1:0] RATED_TORQUE = 12'h400;
	localparam logic [THERM_W-1:0] THERM_COOL = 32'h0000_0100;
	localparam logic [THERM_W-1:0] THERM_LIMIT = 32'h3000_0000;

	// Event and fault bit positions
	localparam int EV_OVERSPEED = 0;
	localparam int EV_OVERLOAD = 1;
	localparam int EV_ENCODER = 2;
	localparam int EV_VOLTAGE = 3;
	localparam int EV_OVERCURRENT = 4;
	localparam int EV_FAN = 5;
	localparam int EV_SYSTEM = 6;
	localparam int EV_NOTICE = 7;
	localparam int EV_BRAKE = 8;
	localparam int FAULT_W = 7;
	localparam int EV_W = 9;

	// Lamp codes, bit 0 is lamp one
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_SYSTEM = 3'h1;
	localparam logic [2:0] CODE_OVERSPEED = 3'h2;
	localparam logic [2:0] CODE_OVERLOAD = 3'h3;
	localparam logic [2:0] CODE_ENCODER = 3'h4;
	localparam logic [2:0] CODE_VOLTAGE = 3'h5;
	localparam logic [2:0] CODE_OVERCURRENT = 3'h6;
	localparam logic [2:0] CODE_FAN = 3'h7;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_EVENT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_EVENT_CLR = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_EVENT_EN = 8'h10;
	localparam logic [ADDR_W-1:0] REG_SPEED = 8'h14;
	localparam int CTRL_FAULT_CLR = 0;
	localparam int CTRL_NOTICE_CLR = 1;
	localparam logic [EV_W-1:0] EVENT_EN_RST = 9'h000;

	typedef enum logic [2:0] {
		BRK_HELD = 3'b001,
		BRK_RUN = 3'b010,
		BRK_STOP = 3'b100
	} brake_state_t;
endpackage : servo_guard_pkg

// ---- verilog/pin_filter.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_filter #(
	parameter int W = 1
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] pin_o,
	output logic valid_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [2:0] fill_q;

	// Fill marks which stages hold real pin samples, not reset zeros
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			fill_q <= 3'h0;
		end else if (ce_i) begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			fill_q <= {fill_q[1:0], 1'b1};
		end
	end

	// Reset zeros never count as a pin value
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o <= '0;
			valid_o <= 1'b0;
		end else if (ce_i && fill_q[2] && (s2_q == s3_q)) begin
			pin_o <= s3_q;
			valid_o <= 1'b1;
		end
	end
endmodule : pin_filter

// ---- verilog/cycle_timer.sv ----
// Restartable cycle timer with a sticky done flag
`timescale 1ns/1ps
module cycle_timer #(
	parameter int CYCLES = 1
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic restart_i,
	input wire logic run_i,
	output logic done_o
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			if (restart_i) begin
				cnt_q <= '0;
				done_o <= 1'b0;
			end else if (run_i && !done_o) begin
				cnt_q <= cnt_q + 32'h0000_0001;
				done_o <= (cnt_q == 32'(CYCLES - 1));
			end
		end
	end
endmodule : cycle_timer

// ---- verilog/servo_guard.sv ----
// Servo brake interlock and fault monitor with Wishbone registers
// What this block does
// - Release brake-hold after servo-off when speed below 100 r/min or 500 ms elapse.
// - Any fault asserts fault output, removes drive and shows its lamp code.
// - Speed above 4950 rpm raises overspeed fault.
// - Torque beyond the thermal overload model raises overload fault.
// - Unreadable encoder data or missing phase signal raises encoder fault.
// - Bus voltage outside 170 to 410 V while running raises voltage fault.
// - Excess stage current or module temperature raises overcurrent fault.
// - Stopped cooling fan raises fan fault with its own lamp pattern.
// - Internal processor error raises system fault on lamp one only.
// - Pulse selector change flashes all lamps, never a fault.
// - Dynamic brake engages about 15 ms after motor de-energises.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module servo_guard #(
	parameter int BRAKE_TMO_CYC = servo_guard_pkg::BRAKE_TIMEOUT_CYC,
	parameter int DYN_CYC = servo_guard_pkg::DYN_BRAKE_CYC,
	parameter int FLASH_CYC = servo_guard_pkg::FLASH_HALF_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [servo_guard_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic run_i,
	input wire logic fan_stall_i,
	input wire logic enc_phase_ok_i,
	input wire logic [3:0] pulse_sel_i,
	input wire logic [servo_guard_pkg::SPEED_W-1:0] speed_i,
	input wire logic [servo_guard_pkg::TORQUE_W-1:0] torque_i,
	input wire logic [servo_guard_pkg::VOLT_W-1:0] vbus_i,
	input wire logic [servo_guard_pkg::CUR_W-1:0] current_i,
	input wire logic [servo_guard_pkg::TEMP_W-1:0] module_temp_i,
	input wire logic enc_read_err_i,
	input wire logic cpu_err_i,
	output logic fault_output_o,
	output logic drive_enable_o,
	output logic brake_hold_output_o,
	output logic dyn_brake_o,
	output logic fault_lamp_one_o,
	output logic fault_lamp_two_o,
	output logic fault_lamp_three_o,
	output logic irq_o
);
	import servo_guard_pkg::*;

	logic [PIN_W-1:0] pins_f;
	logic pins_valid;
	logic run_f;
	logic fan_f;
	logic phase_f;
	logic [3:0] pulse_f;
	logic [THERM_W-1:0] therm_q;
	logic [THERM_W-1:0] therm_d;
	logic [FAULT_W-1:0] cond;
	logic fault_q;
	logic fault_d;
	logic [2:0] code_q;
	logic [2:0] code_d;
	logic servo_on_d;
	brake_state_t state_q;
	brake_state_t state_d;
	logic brake_tmo;
	logic dyn_done;
	logic flash_done;
	logic blink_q;
	logic [3:0] pulse_prev_q;
	logic pulse_seen_q;
	logic pulse_change;
	logic notice_q;
	logic notice_d;
	logic [2:0] lamp_d;
	logic [EV_W-1:0] ev_q;
	logic [EV_W-1:0] ev_d;
	logic [EV_W-1:0] ev_en_q;
	logic [EV_W-1:0] ev_en_d;
	logic [EV_W-1:0] ev_clr;
	logic wb_req;
	logic wb_wr;
	logic fault_clr;
	logic notice_clr;
	logic [31:0] rd_data;
	logic [31:0] status_word;

	pin_filter #(.W(PIN_W)) u_pins (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.pin_i({pulse_sel_i, enc_phase_ok_i, fan_stall_i, run_i}),
		.pin_o(pins_f),
		.valid_o(pins_valid)
	);
	assign run_f = pins_f[0];
	assign fan_f = pins_f[1];
	assign phase_f = pins_f[2];
	assign pulse_f = pins_f[6:3];

	// Bus decode
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	assign fault_clr = wb_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_FAULT_CLR];
	assign notice_clr = wb_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0]
		&& wb_dat_i[CTRL_NOTICE_CLR];
	assign ev_clr = (wb_wr && (wb_adr_i == REG_EVENT_CLR))
		? {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0] & {8{wb_sel_i[0]}}} : '0;

	// Electronic thermal model of motor load
	always_comb begin
		therm_d = therm_q;
		if (torque_i > RATED_TORQUE) begin
			if (therm_q < THERM_LIMIT) begin
				therm_d = therm_q + 32'(torque_i - RATED_TORQUE);
			end
		end else if (therm_q > THERM_COOL) begin
			therm_d = therm_q - THERM_COOL;
		end else begin
			therm_d = '0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			therm_q <= '0;
		end else if (ce_i) begin
			therm_q <= therm_d;
		end
	end

	// Fault detectors
	assign cond[EV_OVERSPEED] = speed_i > OVERSPEED_RPM;
	assign cond[EV_OVERLOAD] = therm_q >= THERM_LIMIT;
	assign cond[EV_ENCODER] = enc_read_err_i || (pins_valid && !phase_f);
	assign cond[EV_VOLTAGE] = drive_enable_o && ((vbus_i < VBUS_MIN_V) || (vbus_i > VBUS_MAX_V));
	assign cond[EV_OVERCURRENT] = (current_i > CURRENT_MAX) || (module_temp_i > TEMP_MAX);
	assign cond[EV_FAN] = pins_valid && fan_f;
	assign cond[EV_SYSTEM] = cpu_err_i;

	function automatic logic [2:0] code_of(input logic [FAULT_W-1:0] c);
		logic [2:0] r;
		r = CODE_NONE;
		if (c[EV_SYSTEM]) r = CODE_SYSTEM;
		else if (c[EV_OVERCURRENT]) r = CODE_OVERCURRENT;
		else if (c[EV_VOLTAGE]) r = CODE_VOLTAGE;
		else if (c[EV_ENCODER]) r = CODE_ENCODER;
		else if (c[EV_OVERLOAD]) r = CODE_OVERLOAD;
		else if (c[EV_OVERSPEED]) r = CODE_OVERSPEED;
		else if (c[EV_FAN]) r = CODE_FAN;
		return r;
	endfunction : code_of

	// Latched fault; a live condition beats the clear
	always_comb begin
		fault_d = (fault_q && !fault_clr) || (|cond);
		code_d = code_q;
		if (!fault_q || fault_clr) begin
			code_d = (|cond) ? code_of(cond) : CODE_NONE;
		end
	end
	assign servo_on_d = run_f && !fault_d;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_q <= 1'b0;
			code_q <= CODE_NONE;
			drive_enable_o <= 1'b0;
		end else if (ce_i) begin
			fault_q <= fault_d;
			code_q <= code_d;
			drive_enable_o <= servo_on_d;
		end
	end
	assign fault_output_o = fault_q;

	// Brake interlock sequence
	always_comb begin
		state_d = state_q;
		case (state_q)
			BRK_HELD: begin
				if (servo_on_d) state_d = BRK_RUN;
			end
			BRK_RUN: begin
				if (!servo_on_d) state_d = BRK_STOP;
			end
			BRK_STOP: begin
				if (servo_on_d) state_d = BRK_RUN;
				else if ((speed_i < BRAKE_SPEED_RPM) || brake_tmo) state_d = BRK_HELD;
			end
			default: state_d = BRK_HELD;
		endcase
	end

	cycle_timer #(.CYCLES(BRAKE_TMO_CYC)) u_brake_tmr (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.restart_i(state_q != BRK_STOP),
		.run_i(state_q == BRK_STOP),
		.done_o(brake_tmo)
	);

	cycle_timer #(.CYCLES(DYN_CYC)) u_dyn_tmr (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.restart_i(drive_enable_o),
		.run_i(!drive_enable_o),
		.done_o(dyn_done)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= BRK_HELD;
			brake_hold_output_o <= 1'b0;
			dyn_brake_o <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			brake_hold_output_o <= (state_d != BRK_HELD);
			dyn_brake_o <= servo_on_d ? 1'b0 : dyn_done;
		end
	end

	// Pulse selector change notice and lamp flashing
	assign pulse_change = pins_valid && pulse_seen_q && (pulse_f != pulse_prev_q);
	assign notice_d = pulse_change || (notice_q && !notice_clr);

	cycle_timer #(.CYCLES(FLASH_CYC)) u_flash_tmr (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.restart_i(flash_done),
		.run_i(1'b1),
		.done_o(flash_done)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_prev_q <= 4'h0;
			pulse_seen_q <= 1'b0;
			notice_q <= 1'b0;
			blink_q <= 1'b0;
		end else if (ce_i) begin
			if (pins_valid) begin
				pulse_prev_q <= pulse_f;
				pulse_seen_q <= 1'b1;
			end
			notice_q <= notice_d;
			if (flash_done) blink_q <= !blink_q;
		end
	end

	// Fault code has priority over the notice
	assign lamp_d = fault_d ? code_d : (notice_d ? {3{blink_q}} : CODE_NONE);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_lamp_one_o <= 1'b0;
			fault_lamp_two_o <= 1'b0;
			fault_lamp_three_o <= 1'b0;
		end else if (ce_i) begin
			fault_lamp_one_o <= lamp_d[0];
			fault_lamp_two_o <= lamp_d[1];
			fault_lamp_three_o <= lamp_d[2];
		end
	end

	// Sticky events, enable and interrupt; set beats clear
	always_comb begin
		ev_d = (ev_q & ~ev_clr) | {brake_hold_output_o && (state_d == BRK_HELD), pulse_change, cond};
		ev_en_d = ev_en_q;
		if (wb_wr && (wb_adr_i == REG_EVENT_EN)) begin
			if (wb_sel_i[0]) ev_en_d[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1]) ev_en_d[8] = wb_dat_i[8];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev_q <= '0;
			ev_en_q <= EVENT_EN_RST;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			ev_q <= ev_d;
			ev_en_q <= ev_en_d;
			irq_o <= |(ev_d & ev_en_d);
		end
	end

	// Register read and acknowledge
	assign status_word = {23'h000000, run_f, notice_q, dyn_brake_o, drive_enable_o,
		brake_hold_output_o, code_q, fault_q};
	always_comb begin
		case (wb_adr_i)
			REG_STATUS: rd_data = status_word;
			REG_EVENT: rd_data = {23'h000000, ev_q};
			REG_EVENT_EN: rd_data = {23'h000000, ev_en_q};
			REG_SPEED: rd_data = {19'h00000, speed_i};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) wb_dat_o <= rd_data;
		end
	end

	sequence s_fresh;
		ce_i && !fault_q;
	endsequence
	sequence s_fault_shown;
		fault_output_o && !drive_enable_o;
	endsequence

	property p_overspeed;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(s_fresh ##0 (cond == 7'h01)) |=> s_fault_shown ##0
			({fault_lamp_three_o, fault_lamp_two_o, fault_lamp_one_o} == CODE_OVERSPEED);
	endproperty
	a_overspeed: assert property (p_overspeed) else $error("overspeed not latched");
	property p_overload;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ce_i && (therm_q >= THERM_LIMIT)) |=> s_fault_shown;
	endproperty
	a_overload: assert property (p_overload) else $error("overload not latched");
	property p_encoder;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ce_i && enc_read_err_i) |=> s_fault_shown;
	endproperty
	a_encoder: assert property (p_encoder) else $error("encoder fault missed");
	property p_voltage;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ce_i && drive_enable_o && (vbus_i > VBUS_MAX_V)) |=> s_fault_shown;
	endproperty
	a_voltage: assert property (p_voltage) else $error("voltage fault missed");
	property p_overcurrent;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ce_i && (module_temp_i > TEMP_MAX)) |=> s_fault_shown;
	endproperty
	a_overcurrent: assert property (p_overcurrent) else $error("overcurrent missed");
	property p_fan_code;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(s_fresh ##0 (cond == 7'h20)) |=>
			({fault_lamp_three_o, fault_lamp_two_o, fault_lamp_one_o} == CODE_FAN);
	endproperty
	a_fan_code: assert property (p_fan_code) else $error("fan lamp pattern wrong");
	property p_system_code;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(s_fresh ##0 cpu_err_i) |=> s_fault_shown ##0
			({fault_lamp_three_o, fault_lamp_two_o, fault_lamp_one_o} == 3'h1);
	endproperty
	a_system_code: assert property (p_system_code) else $error("system lamp wrong");
	property p_notice;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(s_fresh ##0 pulse_change && (cond == 7'h00)) |=> notice_q && !fault_output_o
			&& (fault_lamp_one_o == fault_lamp_two_o) && (fault_lamp_two_o == fault_lamp_three_o);
	endproperty
	a_notice: assert property (p_notice) else $error("notice treated as fault");
	property p_latched;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ce_i && fault_q && !fault_clr) |=> s_fault_shown;
	endproperty
	a_latched: assert property (p_latched) else $error("fault dropped without clear");
	property p_brake_slow;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ce_i && (state_q == BRK_STOP) && !servo_on_d && (speed_i < BRAKE_SPEED_RPM))
			|=> !brake_hold_output_o;
	endproperty
	a_brake_slow: assert property (p_brake_slow) else $error("brake hold kept at low speed");
	property p_dyn_brake;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(dyn_brake_o) |-> !drive_enable_o && $past(!drive_enable_o);
	endproperty
	a_dyn_brake: assert property (p_dyn_brake) else $error("dynamic brake while driven");
endmodule : servo_guard

// ---- verif/host_model.sv ----
// Host position controller model: run command, command pulses, fault watch
`timescale 1ns/1ps
module host_model #(
	parameter int RELAY_CYC = 4,
	parameter int IGNORE_CYC = 100
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic go_i,
	input wire logic brake_hold_i,
	input wire logic fault_i,
	output logic run_o,
	output logic pulse_o,
	output logic fault_seen_o
);
	int relay_q;
	int boot_q;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_o <= 1'b0;
			relay_q <= 0;
			pulse_o <= 1'b0;
		end else begin
			run_o <= go_i;
			// Pulses wait for brake release plus relay time
			if (!go_i || !brake_hold_i) relay_q <= 0;
			else if (relay_q < RELAY_CYC) relay_q <= relay_q + 1;
			pulse_o <= (relay_q == RELAY_CYC) && !pulse_o;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) boot_q <= 0;
		else if (boot_q < IGNORE_CYC) boot_q <= boot_q + 1;
	end
	// Fault line untrusted during the boot window
	assign fault_seen_o = fault_i && (boot_q == IGNORE_CYC);
endmodule : host_model

// ---- verif/servo_guard_bench.sv ----
// Self-checking bench for the servo brake interlock and fault monitor
`timescale 1ns/1ps
module servo_guard_bench;
	import servo_guard_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0, psel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic go = 1'b0, fan = 1'b0, phase = 1'b1, enc = 1'b0, cpu = 1'b0;
	logic ce = 1'b1;
	logic [12:0] speed = 13'h0000;
	logic [11:0] torque = 12'h000, cur = 12'h000;
	logic [8:0] vbus = 9'h12C;
	logic [7:0] temp = 8'h20;
	logic run, fault, drive, hold, dyn, l1, l2, l3, irq, pulse, fseen;
	logic [2:0] codes [9] = '{3'h1, 3'h6, 3'h6, 3'h5, 3'h5, 3'h4, 3'h4, 3'h2, 3'h7};
	int error_cnt = 0;
	int n_compared = 0;
	int k;
	always #25 clk = ~clk;
	servo_guard #(.BRAKE_TMO_CYC(200), .DYN_CYC(30), .FLASH_CYC(8)) dut_u (
		.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .run_i(run),
		.fan_stall_i(fan), .enc_phase_ok_i(phase), .pulse_sel_i(psel),
		.speed_i(speed), .torque_i(torque), .vbus_i(vbus), .current_i(cur),
		.module_temp_i(temp), .enc_read_err_i(enc), .cpu_err_i(cpu),
		.fault_output_o(fault), .drive_enable_o(drive),
		.brake_hold_output_o(hold), .dyn_brake_o(dyn), .fault_lamp_one_o(l1),
		.fault_lamp_two_o(l2), .fault_lamp_three_o(l3), .irq_o(irq));
	host_model host_u (.clk_sys_i(clk), .rst_n_i(rst_n), .go_i(go),
		.brake_hold_i(hold), .fault_i(fault), .run_o(run), .pulse_o(pulse),
		.fault_seen_o(fseen));
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1) begin
			error_cnt++;
			tally_and_finish();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	function automatic logic pick(input int s);
		case (s)
			0: return drive;
			1: return hold;
			2: return fault;
			default: return dyn;
		endcase
	endfunction : pick
	task automatic waitv(input int s, input logic v, input int n);
		int i;
		for (i = 0; i < n && pick(s) !== v; i++) @(posedge clk);
		n_compared++;
		if (pick(s) !== v) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : waitv
	task automatic cause(input int c, input logic on);
		case (c)
			0: cpu <= on;
			1: cur <= on ? 12'hC01 : 12'h000;
			2: temp <= on ? 8'h65 : 8'h20;
			3: vbus <= on ? 9'h0A9 : 9'h12C;
			4: vbus <= on ? 9'h19B : 9'h12C;
			5: enc <= on;
			6: phase <= !on;
			7: speed <= on ? 13'h1357 : 13'h0000;
			default: fan <= on;
		endcase
	endtask : cause
	initial begin
		tick(3);
		chk({fault, drive, hold, l1, l2, l3}, 32'h0);
		tick(3);
		rst_n <= 1'b1;
		tick(4);
		rd(REG_EVENT_EN, 32'h0);
		rd(REG_EVENT, 32'h0);
		wb(1'b1, 8'h40, 32'hFFFF);
		rd(8'h40, 32'h0);
		wb(1'b1, REG_EVENT_EN, 32'h1FF);
		rd(REG_EVENT_EN, 32'h1FF);
		wb(1'b1, REG_EVENT_EN, 32'h0);
		rd(REG_EVENT_CLR, 32'h0);
		go <= 1'b1;
		waitv(0, 1'b1, 20);
		chk(hold, 1'b1);
		chk(pulse, 1'b0);
		rd(REG_STATUS, 32'h130);
		speed <= 13'h00C8;
		rd(REG_SPEED, 32'h0C8);
		go <= 1'b0;
		waitv(0, 1'b0, 20);
		tick(20);
		chk(hold, 1'b1);
		speed <= 13'h0032;
		waitv(1, 1'b0, 4);
		speed <= 13'h0BB8;
		go <= 1'b1;
		waitv(1, 1'b1, 20);
		waitv(3, 1'b0, 5);
		go <= 1'b0;
		waitv(0, 1'b0, 20);
		tick(25);
		chk(dyn, 1'b0);
		waitv(3, 1'b1, 15);
		tick(130);
		chk(hold, 1'b1);
		waitv(1, 1'b0, 60);
		speed <= 13'h0000;
		go <= 1'b1;
		waitv(3, 1'b0, 20);
		waitv(0, 1'b1, 20);
		cur <= 12'hC00;
		temp <= 8'h64;
		vbus <= 9'h0AA;
		speed <= 13'h1356;
		torque <= 12'hFFF;
		tick(10);
		vbus <= 9'h19A;
		tick(10);
		chk(fault, 1'b0);
		torque <= 12'h000;
		cause(1, 1'b0);
		cause(2, 1'b0);
		cause(3, 1'b0);
		cause(7, 1'b0);
		tick(5);
		for (k = 0; k < 9; k++) begin
			cause(k, 1'b1);
			waitv(2, 1'b1, 12);
			chk(drive, 1'b0);
			chk({l3, l2, l1}, codes[k]);
			chk(fseen, 1'b1);
			wb(1'b1, REG_CTRL, 32'h1);
			tick(3);
			chk(fault, 1'b1);
			cause(k, 1'b0);
			tick(8);
			chk({fault, drive}, 2'h2);
			wb(1'b1, REG_CTRL, 32'h1);
			waitv(2, 1'b0, 10);
			waitv(0, 1'b1, 20);
		end
		wb(1'b1, REG_EVENT_CLR, 32'h1FF);
		rd(REG_EVENT, 32'h0);
		cause(0, 1'b1);
		waitv(1, 1'b0, 20);
		tick(2);
		chk(irq, 1'b0);
		rd(REG_EVENT, 32'h140);
		wb(1'b1, REG_EVENT_EN, 32'h040);
		tick(1);
		chk(irq, 1'b1);
		cause(0, 1'b0);
		tick(2);
		wb(1'b1, REG_EVENT_CLR, 32'h040);
		tick(1);
		chk(irq, 1'b0);
		wb(1'b1, REG_CTRL, 32'h1);
		waitv(0, 1'b1, 20);
		psel <= 4'h5;
		for (k = 0; k < 40 && l1 !== 1'b1; k++) @(posedge clk);
		chk({l3, l2, l1, fault}, 4'hE);
		for (k = 0; k < 12 && l1 !== 1'b0; k++) @(posedge clk);
		chk({l3, l2, l1}, 3'h0);
		wb(1'b1, REG_CTRL, 32'h2);
		q = 32'h0;
		for (k = 0; k < 24; k++) begin
			@(posedge clk);
			q = q | {l3, l2, l1, fault};
		end
		chk(q, 32'h0);
		ce <= 1'b0;
		go <= 1'b0;
		tick(20);
		chk({drive, hold, fault}, 3'h6);
		ce <= 1'b1;
		waitv(0, 1'b0, 20);
		tally_and_finish();
	end
endmodule : servo_guard_bench
